/* File: adc_link_map.svh */
// Purpose: Constants shared by both ends of the converter serial link.
// Assumes: The system clock runs at 100 MHz.
// Notes: Definitions only; included by bare name.
`ifndef ADC_LINK_MAP_SVH
`define ADC_LINK_MAP_SVH

// System clock rate and the legal master clock range in kHz.
`define SYS_CLK_KHZ 100000
`define MCLK_MIN_KHZ 500
`define MCLK_MAX_KHZ 40000
// Modulator clock range, half the master clock.
`define MODULATOR_CLOCK_MIN_KHZ 250
`define MODULATOR_CLOCK_MAX_KHZ 20000
// Master clock half period in system cycles, rounded up so the rate never passes the maximum.
`define MCLK_HALF_SYS ((`SYS_CLK_KHZ + 2 * `MCLK_MAX_KHZ - 1) / (2 * `MCLK_MAX_KHZ))

// Word lengths and the longest frame strobe low time in serial clock periods.
`define OUT_WORD_BITS 24
`define IN_WORD_BITS 32
`define FRAME_MAX_SCO 32

// Least pulse widths in master clock periods.
`define RESET_MIN_MCLK 1
`define SYNC_MIN_MCLK 4

// Decimation ratios in modulator clock periods per output word.
`define DEC_RATIO_64 9'h040
`define DEC_RATIO_128 9'h080
`define DEC_RATIO_256 9'h100

`endif

/* File: adc_link_pkg.sv */
// Purpose: Types and decoding shared by both ends of the converter serial link.
// Assumes: adc_link_map.svh supplies the numeric constants.
// Notes: Nothing here is imported; users write adc_link_pkg::name.
`default_nettype none
`include "adc_link_map.svh"

package adc_link_pkg;

  // Selected oversampling ratio.
  typedef enum logic [1:0] {DEC_X64, DEC_X128, DEC_X256} dec_sel_t;

  // Device output frame states.
  typedef enum logic {OF_IDLE, OF_SHIFT} out_state_t;

  // Host write path and host pulse generator states.
  typedef enum logic [1:0] {W_IDLE, W_WAIT, W_SHIFT} wr_state_t;
  typedef enum logic [1:0] {P_IDLE, P_RESET, P_SYNC} pulse_state_t;

  // Modulator clock periods in one output word; the spare code falls back to the fastest rate.
  function automatic logic [8:0] dec_ratio(input dec_sel_t sel);
    unique case (sel)
      DEC_X64: dec_ratio = `DEC_RATIO_64;
      DEC_X128: dec_ratio = `DEC_RATIO_128;
      DEC_X256: dec_ratio = `DEC_RATIO_256;
      default: dec_ratio = `DEC_RATIO_64;
    endcase
  endfunction

endpackage

`default_nettype wire

/* File: adc_link_if.sv */
// Purpose: Pin-level link between the converter port and its host controller.
// Assumes: The host makes the master clock; the device makes the serial clock.
// Notes: The three-state data line idles high when the device does not drive it.
`timescale 1ns/100ps
`default_nettype none

interface adc_link_if;
  logic master_clock;
  logic conv_reset_n;
  logic conv_sync_n;
  logic serial_clock;
  logic frame_strobe_out_n;
  logic serial_word_out;
  logic serial_word_out_oe_n;
  logic serial_word_line;
  logic frame_strobe_in_n;
  logic serial_word_in;

  // Wire level of the data line, modelled as a pull-up while released.
  assign serial_word_line = serial_word_out_oe_n ? 1'b1 : serial_word_out;

  modport device_end (
    input master_clock, conv_reset_n, conv_sync_n, frame_strobe_in_n, serial_word_in,
    output serial_clock, frame_strobe_out_n, serial_word_out, serial_word_out_oe_n
  );

  modport host_end (
    output master_clock, conv_reset_n, conv_sync_n, frame_strobe_in_n, serial_word_in,
    input serial_clock, frame_strobe_out_n, serial_word_line
  );
endinterface

`default_nettype wire

/* File: adc_port_device.sv */
// Purpose: Converter end of the serial link: clocks, framing, shifting and pulse qualification.
// Assumes: Master clock, reset and sync pins arrive from another domain and are synchronised here.
// Notes: The master clock must be slow enough that each phase spans at least two system cycles.
`include "adc_link_map.svh"
`timescale 1ns/100ps
`default_nettype none

module adc_port_device #(
  parameter int OUT_W = `OUT_WORD_BITS,
  parameter int IN_W = `IN_WORD_BITS
) (
  // System clock, reset and clock enable.
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic ce,
  // Conversion data and rate selection.
  input wire logic [OUT_W-1:0] sample_word,
  input wire adc_link_pkg::dec_sel_t dec_sel,
  output logic sample_taken,
  // Words written by the host.
  output logic [IN_W-1:0] write_word,
  output logic write_valid,
  // Core state.
  output logic link_in_reset,
  // Link pins.
  adc_link_if.device_end link
);

  // Synchroniser chains; stage 0 feeds stage 1 only.
  logic [2:0] mclk_sync_q;
  logic [1:0] rst_sync_q;
  logic [1:0] sync_sync_q;
  logic [1:0] fsi_sync_q;
  logic [1:0] sdi_sync_q;

  // Clock generation and qualification state.
  logic core_rst_q;
  logic modulator_clock_q;
  logic sco_q;
  logic [2:0] sync_cnt_q;
  logic [8:0] dec_cnt_q;
  logic pend_q;

  // Output frame state.
  adc_link_pkg::out_state_t ostate_q;
  logic [OUT_W-1:0] shift_q;
  logic [5:0] bit_cnt_q;
  logic fso_n_q;
  logic sdo_q;
  logic sdo_oe_n_q;

  // Input frame state.
  logic [IN_W-1:0] in_shift_q;
  logic [5:0] in_cnt_q;

  // Edge events, all on system clock cycles.
  wire mclk_rise;
  wire mclk_fall;
  wire modulator_clock_rise;
  wire sco_rise;
  wire sco_fall;
  wire sync_release;
  wire word_due;
  wire frame_start;
  wire frame_last;
  wire in_last;
  wire [IN_W-1:0] in_next;

  assign mclk_rise = mclk_sync_q[1] & ~mclk_sync_q[2];
  assign mclk_fall = ~mclk_sync_q[1] & mclk_sync_q[2];
  assign modulator_clock_rise = mclk_rise & ~modulator_clock_q & ~core_rst_q;
  assign sco_rise = modulator_clock_rise & ~sco_q;
  assign sco_fall = modulator_clock_rise & sco_q;
  assign sync_release = mclk_fall & sync_sync_q[1] & (sync_cnt_q >= 3'(`SYNC_MIN_MCLK));
  assign word_due = modulator_clock_rise & (dec_cnt_q == adc_link_pkg::dec_ratio(dec_sel) - 9'h001);
  assign frame_start = sco_rise & pend_q & (ostate_q == adc_link_pkg::OF_IDLE);
  assign frame_last = bit_cnt_q == 6'(OUT_W - 1);
  assign in_last = in_cnt_q == 6'(IN_W - 1);
  assign in_next = {in_shift_q[IN_W-2:0], sdi_sync_q[1]};

  // Link pins come straight from flip-flops.
  assign link.serial_clock = sco_q;
  assign link.frame_strobe_out_n = fso_n_q;
  assign link.serial_word_out = sdo_q;
  assign link.serial_word_out_oe_n = sdo_oe_n_q;
  assign link_in_reset = core_rst_q;

  // Two flip-flops on every pin from the host before any logic reads it.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      mclk_sync_q <= 3'h0;
      rst_sync_q <= 2'h0;
      sync_sync_q <= 2'h3;
      fsi_sync_q <= 2'h3;
      sdi_sync_q <= 2'h0;
    end else if (ce) begin
      mclk_sync_q <= {mclk_sync_q[1:0], link.master_clock};
      rst_sync_q <= {rst_sync_q[0], link.conv_reset_n};
      sync_sync_q <= {sync_sync_q[0], link.conv_sync_n};
      fsi_sync_q <= {fsi_sync_q[0], link.frame_strobe_in_n};
      sdi_sync_q <= {sdi_sync_q[0], link.serial_word_in};
    end
  end

  // The reset pin is looked at only on master clock rises, so a pulse shorter than one
  // period may be missed entirely and the release lands on a rise.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      core_rst_q <= 1'b1;
    end else if (ce && mclk_rise) begin
      core_rst_q <= ~rst_sync_q[1];
    end
  end

  // Modulator clock is the master clock divided by two; the serial clock toggles once per
  // modulator period so each phase lasts one modulator period.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      modulator_clock_q <= 1'b0;
      sco_q <= 1'b0;
    end else if (ce) begin
      if (core_rst_q || sync_release) begin
        modulator_clock_q <= 1'b0;
        sco_q <= 1'b0;
      end else if (mclk_rise) begin
        modulator_clock_q <= ~modulator_clock_q;
        if (!modulator_clock_q) begin
          sco_q <= ~sco_q;
        end
      end
    end
  end

  // Sync qualification counts falling master edges while low; only a long enough pulse
  // restarts the word phase, shorter glitches are dropped.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sync_cnt_q <= 3'h0;
    end else if (ce && mclk_fall) begin
      if (!sync_sync_q[1]) begin
        if (sync_cnt_q < 3'(`SYNC_MIN_MCLK)) begin
          sync_cnt_q <= sync_cnt_q + 3'h1;
        end
      end else begin
        sync_cnt_q <= 3'h0;
      end
    end
  end

  // Decimation counter marks one word per ratio of modulator periods; a new word wins
  // over the clear that a starting frame gives.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      dec_cnt_q <= 9'h000;
      pend_q <= 1'b0;
    end else if (ce) begin
      if (core_rst_q || sync_release) begin
        dec_cnt_q <= 9'h000;
        pend_q <= 1'b0;
      end else begin
        if (word_due) begin
          dec_cnt_q <= 9'h000;
        end else if (modulator_clock_rise) begin
          dec_cnt_q <= dec_cnt_q + 9'h001;
        end
        pend_q <= word_due | (pend_q & ~frame_start);
      end
    end
  end

  // Output framing: strobe falls and the MSB is loaded on a serial rise; each later rise
  // shifts one bit; after the last bit the strobe rises, so it stays low OUT_W periods.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ostate_q <= adc_link_pkg::OF_IDLE;
      shift_q <= '0;
      bit_cnt_q <= 6'h00;
      fso_n_q <= 1'b1;
      sdo_q <= 1'b0;
      sample_taken <= 1'b0;
    end else if (ce) begin
      sample_taken <= frame_start;
      if (core_rst_q) begin
        ostate_q <= adc_link_pkg::OF_IDLE;
        fso_n_q <= 1'b1;
      end else if (frame_start) begin
        ostate_q <= adc_link_pkg::OF_SHIFT;
        shift_q <= sample_word;
        sdo_q <= sample_word[OUT_W-1];
        bit_cnt_q <= 6'h00;
        fso_n_q <= 1'b0;
      end else if (sco_rise && ostate_q == adc_link_pkg::OF_SHIFT) begin
        if (frame_last) begin
          ostate_q <= adc_link_pkg::OF_IDLE;
          fso_n_q <= 1'b1;
        end else begin
          shift_q <= {shift_q[OUT_W-2:0], 1'b0};
          sdo_q <= shift_q[OUT_W-2];
          bit_cnt_q <= bit_cnt_q + 6'h01;
        end
      end
    end
  end

  // The data line is enabled the cycle after the strobe is seen low and released the cycle after it rises.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sdo_oe_n_q <= 1'b1;
    end else if (ce) begin
      sdo_oe_n_q <= fso_n_q | (ostate_q != adc_link_pkg::OF_SHIFT) | core_rst_q;
    end
  end

  // Input frames: each serial fall with the host strobe low takes one bit, MSB first.
  // A strobe released early drops the partial word.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      in_shift_q <= '0;
      in_cnt_q <= 6'h00;
      write_word <= '0;
      write_valid <= 1'b0;
    end else if (ce) begin
      write_valid <= 1'b0;
      if (sco_fall) begin
        if (!fsi_sync_q[1]) begin
          in_shift_q <= in_next;
          if (in_last) begin
            write_word <= in_next;
            write_valid <= 1'b1;
            in_cnt_q <= 6'h00;
          end else begin
            in_cnt_q <= in_cnt_q + 6'h01;
          end
        end else begin
          in_cnt_q <= 6'h00;
        end
      end
    end
  end

endmodule

`default_nettype wire

/* File: adc_port_host.sv */
// Purpose: Host end of the converter serial link: master clock, pulses, reads and writes.
// Assumes: Serial clock, strobe and data from the converter are synchronised here.
// Notes: Serial clock phases must each span at least six system cycles.
`include "adc_link_map.svh"
`timescale 1ns/100ps
`default_nettype none

module adc_port_host #(
  parameter int OUT_W = `OUT_WORD_BITS,
  parameter int IN_W = `IN_WORD_BITS,
  parameter int MCLK_HALF = `MCLK_HALF_SYS
) (
  // System clock, reset and clock enable.
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic ce,
  // Write requests.
  input wire logic write_req,
  input wire logic [IN_W-1:0] write_data,
  output logic write_ready,
  // Pulse requests.
  input wire logic reset_req,
  input wire logic sync_req,
  output logic pulse_busy,
  // Received conversion words.
  output logic [OUT_W-1:0] read_word,
  output logic read_valid,
  // Link pins.
  adc_link_if.host_end link
);

  logic [7:0] div_cnt_q;
  logic mclk_q;
  adc_link_pkg::pulse_state_t pstate_q;
  logic [2:0] pcnt_q;
  logic rst_n_q;
  logic sync_n_q;
  logic [2:0] sco_sync_q;
  logic [2:0] fso_sync_q;
  logic [2:0] sdo_sync_q;
  adc_link_pkg::wr_state_t wstate_q;
  logic [IN_W-1:0] wshift_q;
  logic [5:0] wcnt_q;
  logic fsi_n_q;
  logic sdi_q;
  logic [OUT_W-1:0] rshift_q;
  logic [5:0] rcnt_q;

  wire div_wrap;
  wire mclk_rise_ev;
  wire mclk_fall_ev;
  wire sco_rise;
  wire [OUT_W-1:0] rnext;

  assign div_wrap = div_cnt_q == 8'(MCLK_HALF - 1);
  assign mclk_rise_ev = div_wrap & ~mclk_q;
  assign mclk_fall_ev = div_wrap & mclk_q;
  assign sco_rise = sco_sync_q[1] & ~sco_sync_q[2];
  assign rnext = {rshift_q[OUT_W-2:0], sdo_sync_q[2]};

  assign link.master_clock = mclk_q;
  assign link.conv_reset_n = rst_n_q;
  assign link.conv_sync_n = sync_n_q;
  assign link.frame_strobe_in_n = fsi_n_q;
  assign link.serial_word_in = sdi_q;

  // Master clock divider; the default half period keeps the rate within the legal range.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      div_cnt_q <= 8'h00;
      mclk_q <= 1'b0;
    end else if (ce) begin
      div_cnt_q <= div_wrap ? 8'h00 : div_cnt_q + 8'h01;
      if (div_wrap) begin
        mclk_q <= ~mclk_q;
      end
    end
  end

  // Reset pulses span master falls so the release sits between rises; sync pulses span
  // rises so the release sits between falls. Reset takes priority over sync.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pstate_q <= adc_link_pkg::P_IDLE;
      pcnt_q <= 3'h0;
      rst_n_q <= 1'b1;
      sync_n_q <= 1'b1;
      pulse_busy <= 1'b0;
    end else if (ce) begin
      unique case (pstate_q)
        adc_link_pkg::P_IDLE: begin
          pcnt_q <= 3'h0;
          if (reset_req && mclk_fall_ev) begin
            pstate_q <= adc_link_pkg::P_RESET;
            rst_n_q <= 1'b0;
            pulse_busy <= 1'b1;
          end else if (sync_req && !reset_req && mclk_rise_ev) begin
            pstate_q <= adc_link_pkg::P_SYNC;
            sync_n_q <= 1'b0;
            pulse_busy <= 1'b1;
          end
        end
        adc_link_pkg::P_RESET: begin
          if (mclk_fall_ev) begin
            if (pcnt_q == 3'(`RESET_MIN_MCLK - 1)) begin
              rst_n_q <= 1'b1;
              pstate_q <= adc_link_pkg::P_IDLE;
              pulse_busy <= 1'b0;
            end else begin
              pcnt_q <= pcnt_q + 3'h1;
            end
          end
        end
        adc_link_pkg::P_SYNC: begin
          if (mclk_rise_ev) begin
            if (pcnt_q == 3'(`SYNC_MIN_MCLK - 1)) begin
              sync_n_q <= 1'b1;
              pstate_q <= adc_link_pkg::P_IDLE;
              pulse_busy <= 1'b0;
            end else begin
              pcnt_q <= pcnt_q + 3'h1;
            end
          end
        end
        default: begin
          pstate_q <= adc_link_pkg::P_IDLE;
        end
      endcase
    end
  end

  // Two flip-flops on every converter pin; a third stage finds serial clock edges and
  // keeps strobe and data as they stood just before each edge.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sco_sync_q <= 3'h0;
      fso_sync_q <= 3'h7;
      sdo_sync_q <= 3'h7;
    end else if (ce) begin
      sco_sync_q <= {sco_sync_q[1:0], link.serial_clock};
      fso_sync_q <= {fso_sync_q[1:0], link.frame_strobe_out_n};
      sdo_sync_q <= {sdo_sync_q[1:0], link.serial_word_line};
    end
  end

  // Reads: strobe and data lag the clock by one more stage, so values at a seen rise are
  // those that stood just before that rise; the bit launched on the same rise is not taken.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rshift_q <= '0;
      rcnt_q <= 6'h00;
      read_word <= '0;
      read_valid <= 1'b0;
    end else if (ce) begin
      read_valid <= 1'b0;
      if (sco_rise) begin
        if (!fso_sync_q[2]) begin
          rshift_q <= rnext;
          if (rcnt_q == 6'(OUT_W - 1)) begin
            read_word <= rnext;
            read_valid <= 1'b1;
            rcnt_q <= 6'h00;
          end else begin
            rcnt_q <= rcnt_q + 6'h01;
          end
        end else begin
          rcnt_q <= 6'h00;
        end
      end
    end
  end

  // Writes: strobe and MSB change on a serial rise, ahead of the fall that samples them;
  // the strobe rises IN_W rises later.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      wstate_q <= adc_link_pkg::W_IDLE;
      wshift_q <= '0;
      wcnt_q <= 6'h00;
      fsi_n_q <= 1'b1;
      sdi_q <= 1'b0;
      write_ready <= 1'b1;
    end else if (ce) begin
      unique case (wstate_q)
        adc_link_pkg::W_IDLE: begin
          if (write_req) begin
            wshift_q <= write_data;
            write_ready <= 1'b0;
            wstate_q <= adc_link_pkg::W_WAIT;
          end
        end
        adc_link_pkg::W_WAIT: begin
          if (sco_rise) begin
            fsi_n_q <= 1'b0;
            sdi_q <= wshift_q[IN_W-1];
            wcnt_q <= 6'h00;
            wstate_q <= adc_link_pkg::W_SHIFT;
          end
        end
        adc_link_pkg::W_SHIFT: begin
          if (sco_rise) begin
            if (wcnt_q == 6'(IN_W - 1)) begin
              fsi_n_q <= 1'b1;
              write_ready <= 1'b1;
              wstate_q <= adc_link_pkg::W_IDLE;
            end else begin
              wshift_q <= {wshift_q[IN_W-2:0], 1'b0};
              sdi_q <= wshift_q[IN_W-2];
              wcnt_q <= wcnt_q + 6'h01;
            end
          end
        end
        default: begin
          wstate_q <= adc_link_pkg::W_IDLE;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

/* File: adc_frame_serial_port_monitor.sv */
// Purpose: Concurrent checks on the converter serial link signals.
// Assumes: Master clock phase of two system cycles, serial phase of eight.
// Notes: Sees the interface signals only; instantiated beside the link.
`timescale 1ns/100ps
`default_nettype none

module adc_frame_serial_port_monitor #(
  parameter int OUT_W = 24,
  parameter int IN_W = 32
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic reset_n,
  // Link signals.
  input wire logic master_clock,
  input wire logic conv_reset_n,
  input wire logic conv_sync_n,
  input wire logic serial_clock,
  input wire logic frame_strobe_out_n,
  input wire logic serial_word_out,
  input wire logic serial_word_out_oe_n,
  input wire logic frame_strobe_in_n
);
  logic sco_q;
  logic sco_rise;
  logic [5:0] out_cnt_q;
  logic [5:0] in_cnt_q;
  logic [4:0] quiet_q;

  default clocking mon_cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  // Rise detection on the serial clock.
  assign sco_rise = serial_clock & ~sco_q;

  // Counts rises under each strobe, and cycles since the last pulse, since pulses may cut a clock phase short.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sco_q <= 1'b0;
      out_cnt_q <= 6'h00;
      in_cnt_q <= 6'h00;
      quiet_q <= 5'h00;
    end else begin
      sco_q <= serial_clock;
      out_cnt_q <= frame_strobe_out_n ? 6'h00 : out_cnt_q + {5'h00, sco_rise};
      in_cnt_q <= frame_strobe_in_n ? 6'h00 : in_cnt_q + {5'h00, sco_rise};
      quiet_q <= (!conv_reset_n || !conv_sync_n) ? 5'h00 : quiet_q + {4'h0, quiet_q != 5'h1F};
    end
  end

  AST_MCLK_PHASE: assert property ($rose(master_clock) |-> master_clock[*2] ##1 !master_clock[*2] ##1 master_clock)
    else $error("master clock phase wrong");
  AST_SCO_PHASE: assert property (disable iff (!reset_n || quiet_q != 5'h1F)
    $rose(serial_clock) |-> serial_clock[*8] ##1 !serial_clock[*8] ##1 serial_clock)
    else $error("serial clock phase wrong");
  AST_STROBE_FALL: assert property ($fell(frame_strobe_out_n) |-> $rose(serial_clock))
    else $error("strobe fell off a serial rise");
  AST_OE_AFTER: assert property ($fell(serial_word_out_oe_n) |-> !frame_strobe_out_n && !$past(frame_strobe_out_n))
    else $error("data enabled before strobe fell");
  AST_BIT_HOLD: assert property (!frame_strobe_out_n && !$rose(serial_clock) |-> $stable(serial_word_out))
    else $error("data changed off a serial rise");
  AST_STROBE_RISE: assert property ($rose(frame_strobe_out_n) |-> $rose(serial_clock))
    else $error("strobe rose off a serial rise");
  AST_OUT_LEN: assert property (!frame_strobe_out_n |-> out_cnt_q <= OUT_W)
    else $error("output strobe low too long");
  AST_IN_LEN: assert property (!frame_strobe_in_n |-> in_cnt_q <= IN_W)
    else $error("input strobe low too long");
  AST_IN_SETUP: assert property ($fell(frame_strobe_in_n) |-> serial_clock[*3])
    else $error("input strobe too close to a fall");
  AST_RESET_PULSE: assert property ($rose(conv_reset_n) |-> !master_clock && !$past(conv_reset_n, 4))
    else $error("reset pulse short or misplaced");
  AST_SYNC_PULSE: assert property ($rose(conv_sync_n) |-> master_clock && !$past(conv_sync_n, 16))
    else $error("sync pulse short or misplaced");
endmodule

`default_nettype wire

/* File: adc_frame_serial_port_test.sv */
// Purpose: Self-checking bench for both ends of the converter serial link.
// Assumes: 100 MHz system clock; master clock phase of two system cycles.
// Notes: A second device end faces a bench-made master clock and reset.
`timescale 1ns/100ps
`default_nettype none

module adc_frame_serial_port_test;
  localparam int MCLK_HALF = 2;
  logic sys_clk;
  logic reset_n;
  logic [23:0] sample_word;
  adc_link_pkg::dec_sel_t dec_sel;
  logic sample_taken, write_valid, link_in_reset, lir_b, write_req, write_ready;
  logic reset_req, sync_req, pulse_busy, read_valid;
  logic [31:0] write_word, write_data;
  logic [23:0] read_word;
  int n_errors, cmp_count;
  int cycles = 0;
  adc_link_if link();
  adc_link_if link_b();

  adc_port_device u_adc_port_device (.sys_clk(sys_clk), .reset_n(reset_n), .ce(1'b1), .sample_word(sample_word),
    .dec_sel(dec_sel), .sample_taken(sample_taken), .write_word(write_word), .write_valid(write_valid),
    .link_in_reset(link_in_reset), .link(link));
  adc_port_host #(.MCLK_HALF(MCLK_HALF)) u_adc_port_host (.sys_clk(sys_clk), .reset_n(reset_n), .ce(1'b1),
    .write_req(write_req), .write_data(write_data), .write_ready(write_ready), .reset_req(reset_req),
    .sync_req(sync_req), .pulse_busy(pulse_busy), .read_word(read_word), .read_valid(read_valid), .link(link));
  adc_port_device u_adc_port_device_b (.sys_clk(sys_clk), .reset_n(reset_n), .ce(1'b1), .sample_word(sample_word),
    .dec_sel(dec_sel), .sample_taken(), .write_word(), .write_valid(), .link_in_reset(lir_b), .link(link_b));
  adc_frame_serial_port_monitor #(.OUT_W(24), .IN_W(32)) u_adc_frame_serial_port_monitor (.sys_clk(sys_clk),
    .reset_n(reset_n), .master_clock(link.master_clock), .conv_reset_n(link.conv_reset_n),
    .conv_sync_n(link.conv_sync_n), .serial_clock(link.serial_clock), .frame_strobe_out_n(link.frame_strobe_out_n),
    .serial_word_out(link.serial_word_out), .serial_word_out_oe_n(link.serial_word_out_oe_n),
    .frame_strobe_in_n(link.frame_strobe_in_n));

  // System clock and a free-running, unrelated master clock for the second end.
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    link_b.master_clock = 1'b0;
    #3;
    forever #40 link_b.master_clock = ~link_b.master_clock;
  end

  // Cuts a hang short; the tests need well under half this many cycles.
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      n_errors++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: seen %h, expected %h", $time, seen, exp);
    end
  endtask

  // Waits for the output strobe to fall and returns the cycle number.
  task automatic wait_fall(output int t);
    logic prev;
    prev = link.frame_strobe_out_n;
    for (int k = 0; k < 3000; k++) begin
      @(negedge sys_clk);
      if (prev === 1'b1 && link.frame_strobe_out_n === 1'b0) break;
      prev = link.frame_strobe_out_n;
    end
    t = int'($time / 10);
  endtask

  // Every decimation choice: frame spacing, first bit and the whole word; the last word ends in a low MSB.
  task automatic t_read();
    int t1, t2, t3;
    int ratio [3] = '{64, 128, 256};
    logic [23:0] word [3] = '{24'h5AC396, 24'hFF0001, 24'h000080};
    for (int m = 0; m < 3; m++) begin
      @(negedge sys_clk);
      sample_word = word[m];
      dec_sel = adc_link_pkg::dec_sel_t'(m);
      wait_fall(t1);
      wait_fall(t2);
      wait_fall(t3);
      check(32'(link.serial_word_out), 32'(word[m][23]));
      check(32'(t3 - t2), 32'(ratio[m] * 4 * MCLK_HALF));
      for (int k = 0; k < 4 && sample_taken !== 1'b1; k++) @(negedge sys_clk);
      check(32'(sample_taken), 32'h00000001);
      for (int k = 0; k < 600 && read_valid !== 1'b1; k++) @(negedge sys_clk);
      check(32'(read_word), 32'(word[m]));
    end
    $display("read test done");
  endtask

  // Two writes back to back, with both end bits set in the second.
  task automatic t_write();
    logic [31:0] words [2] = '{32'h7E81C3A5, 32'h80000001};
    for (int w = 0; w < 2; w++) begin
      for (int k = 0; k < 900 && write_ready !== 1'b1; k++) @(negedge sys_clk);
      write_data = words[w];
      write_req = 1'b1;
      for (int k = 0; k < 900 && write_ready !== 1'b0; k++) @(negedge sys_clk);
      write_req = 1'b0;
      for (int k = 0; k < 900 && write_valid !== 1'b1; k++) @(negedge sys_clk);
      check(write_word, words[w]);
    end
    $display("write test done");
  endtask

  // A reset pulse must reach the converter core; a sync pulse must not.
  task automatic t_pulse(input logic is_sync);
    logic seen;
    seen = 1'b0;
    @(negedge sys_clk);
    sync_req = is_sync;
    reset_req = !is_sync;
    for (int k = 0; k < 20 && pulse_busy !== 1'b1; k++) @(negedge sys_clk);
    sync_req = 1'b0;
    reset_req = 1'b0;
    check(32'(pulse_busy), 32'h00000001);
    for (int k = 0; k < 40 && pulse_busy !== 1'b0; k++) begin
      @(negedge sys_clk);
      seen |= link_in_reset;
    end
    for (int k = 0; k < 12; k++) begin
      @(negedge sys_clk);
      seen |= link_in_reset;
    end
    check(32'(seen), 32'(!is_sync));
    check(32'(link_in_reset), 32'h00000000);
    $display("pulse test done");
  endtask

  // The bench holds the second end's reset for two master periods and releases it between master rises.
  task automatic t_far_reset();
    @(negedge link_b.master_clock);
    @(negedge sys_clk);
    link_b.conv_reset_n = 1'b0;
    repeat (2) @(negedge link_b.master_clock);
    @(negedge sys_clk);
    check(32'(lir_b), 32'h00000001);
    link_b.conv_reset_n = 1'b1;
    for (int k = 0; k < 30 && lir_b !== 1'b0; k++) @(negedge sys_clk);
    check(32'(lir_b), 32'h00000000);
    $display("far reset test done");
  endtask

  // Inputs settle at time zero, reset holds ten cycles, then the tests run in turn.
  initial begin
    reset_n = 1'b0;
    sample_word = 24'h000000;
    dec_sel = adc_link_pkg::DEC_X64;
    write_req = 1'b0;
    write_data = 32'h00000000;
    reset_req = 1'b0;
    sync_req = 1'b0;
    link_b.conv_reset_n = 1'b1;
    link_b.conv_sync_n = 1'b1;
    link_b.frame_strobe_in_n = 1'b1;
    link_b.serial_word_in = 1'b0;
    n_errors = 0;
    cmp_count = 0;
    repeat (10) @(negedge sys_clk);
    reset_n = 1'b1;
    repeat (40) @(negedge sys_clk);
    t_read();
    t_write();
    t_pulse(1'b1);
    t_pulse(1'b0);
    t_far_reset();
    give_verdict();
  end
endmodule

`default_nettype wire
